//--- core/cfm_monitor.sv
// contactor feedback monitor with channel and range strap handling
// assumes RELEASE_REQ, NONLOCK_FAULT and NONLOCK_CODE come from logic on CLOCK; other inputs are pins
module cfm_monitor #(
	parameter logic [31:0] FB_WINDOW = cfm_pkg::FB_WINDOW_CYC,
	parameter logic [31:0] AUTORESET = cfm_pkg::AUTORESET_CYC
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic FEEDBACK_CLOSED,
	input wire logic FEEDBACK_CHECK_EN,
	input wire logic SUPPLY_POLARITY_REV,
	input wire logic RANGE_SELECT_PIN,
	input wire logic RELEASE_REQ,
	input wire logic NONLOCK_FAULT,
	input wire logic [7:0] NONLOCK_CODE,
	output logic SAFETY_SWITCH_OUTPUT,
	output logic FEEDBACK_OPEN_ERROR,
	output logic FEEDBACK_CLOSE_ERROR,
	output logic FAULT_INTERLOCK,
	output logic ALTERNATE_LIGHT_CHANNEL,
	output logic REDUCED_LIGHT_POWER,
	output logic [7:0] DISPLAY_CODE
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	cfm_pkg::cfm_state_t s_r;
	cfm_pkg::cfm_state_t s_nxt;
	logic fb;
	logic en;

	assign fb = s_r.fb_s[1];
	assign en = s_r.en_s[1];

	function automatic logic [7:0] chan_code(input logic alt);
		chan_code = alt ? cfm_pkg::DISP_ALT_CH : cfm_pkg::DISP_DEFAULT_CH;
	endfunction : chan_code

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		// first stages are only read by the second stages
		s_nxt.fb_s = {s_r.fb_s[0], FEEDBACK_CLOSED};
		s_nxt.en_s = {s_r.en_s[0], FEEDBACK_CHECK_EN};
		s_nxt.pol_s = {s_r.pol_s[0], SUPPLY_POLARITY_REV};
		s_nxt.rng_s = {s_r.rng_s[0], RANGE_SELECT_PIN};
		// range follows its static pin, no plausibility check on it
		s_nxt.reduce = s_r.rng_s[1];
		// polarity is caught once after the synchroniser settles
		if (!s_r.chan_cap)
		begin
			if (s_r.strap_cnt == cfm_pkg::STRAP_SETTLE)
			begin
				s_nxt.chan_cap = 1'b1;
				s_nxt.alternate_light_channel = s_r.pol_s[1];
				// an early non-locking code must stay visible
				if (s_r.phase == cfm_pkg::ST_OFF)
				begin
					s_nxt.disp = chan_code(s_r.pol_s[1]);
				end
			end
			else
			begin
				s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
			end
		end
		s_nxt.cnt = s_r.cnt + 32'h1;
		case (s_r.phase)
			cfm_pkg::ST_OFF:
			begin
				if (s_r.block_restart && !RELEASE_REQ)
				begin
					s_nxt.block_restart = 1'b0;
				end
				if (NONLOCK_FAULT)
				begin
					s_nxt.phase = cfm_pkg::ST_AUTO_HOLD;
					s_nxt.cnt = 32'h0;
					s_nxt.disp = NONLOCK_CODE;
				end
				else if (RELEASE_REQ && !s_r.block_restart && s_r.chan_cap && (!en || fb))
				begin
					s_nxt.phase = cfm_pkg::ST_WAIT_OPEN;
					s_nxt.safety_switch_output = 1'b1;
					s_nxt.cnt = 32'h0;
				end
			end
			cfm_pkg::ST_WAIT_OPEN:
			begin
				if (en && fb && s_r.cnt == FB_WINDOW - 32'h1)
				begin
					s_nxt.phase = cfm_pkg::ST_LOCKED;
					s_nxt.safety_switch_output = 1'b0;
					s_nxt.feedback_open_error = 1'b1;
					s_nxt.locked = 1'b1;
					s_nxt.disp = cfm_pkg::DISP_FB_OPEN_ERR;
				end
				else if (NONLOCK_FAULT)
				begin
					s_nxt.phase = cfm_pkg::ST_AUTO_HOLD;
					s_nxt.safety_switch_output = 1'b0;
					s_nxt.cnt = 32'h0;
					s_nxt.disp = NONLOCK_CODE;
				end
				else if (!RELEASE_REQ)
				begin
					// opening is still owed; the closing check covers the contactor
					s_nxt.phase = cfm_pkg::ST_WAIT_CLOSE;
					s_nxt.safety_switch_output = 1'b0;
					s_nxt.cnt = 32'h0;
				end
				else if (!en || !fb)
				begin
					s_nxt.phase = cfm_pkg::ST_ON;
				end
			end
			cfm_pkg::ST_ON:
			begin
				if (NONLOCK_FAULT)
				begin
					s_nxt.phase = cfm_pkg::ST_AUTO_HOLD;
					s_nxt.safety_switch_output = 1'b0;
					s_nxt.cnt = 32'h0;
					s_nxt.disp = NONLOCK_CODE;
				end
				else if (!RELEASE_REQ)
				begin
					s_nxt.phase = cfm_pkg::ST_WAIT_CLOSE;
					s_nxt.safety_switch_output = 1'b0;
					s_nxt.cnt = 32'h0;
				end
			end
			cfm_pkg::ST_WAIT_CLOSE:
			begin
				if (!en || fb)
				begin
					s_nxt.phase = cfm_pkg::ST_OFF;
				end
				else if (s_r.cnt == FB_WINDOW - 32'h1)
				begin
					s_nxt.phase = cfm_pkg::ST_LOCKED;
					s_nxt.feedback_close_error = 1'b1;
					s_nxt.locked = 1'b1;
					s_nxt.disp = cfm_pkg::DISP_FB_CLOSE_ERR;
				end
			end
			cfm_pkg::ST_AUTO_HOLD:
			begin
				if (s_r.cnt == AUTORESET - 32'h1)
				begin
					s_nxt.phase = cfm_pkg::ST_OFF;
					s_nxt.block_restart = 1'b1;
					s_nxt.disp = chan_code(s_r.alternate_light_channel);
				end
			end
			cfm_pkg::ST_LOCKED:
			begin
				// only power-on reset leaves this state
				s_nxt.cnt = s_r.cnt;
			end
			default:
			begin
				s_nxt.phase = cfm_pkg::ST_LOCKED;
				s_nxt.safety_switch_output = 1'b0;
				s_nxt.locked = 1'b1;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			s_r <= cfm_pkg::CFM_RESET;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign SAFETY_SWITCH_OUTPUT = s_r.safety_switch_output;
	assign FEEDBACK_OPEN_ERROR = s_r.feedback_open_error;
	assign FEEDBACK_CLOSE_ERROR = s_r.feedback_close_error;
	assign FAULT_INTERLOCK = s_r.locked;
	assign ALTERNATE_LIGHT_CHANNEL = s_r.alternate_light_channel;
	assign REDUCED_LIGHT_POWER = s_r.reduce;
	assign DISPLAY_CODE = s_r.disp;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESETN);

	sequence s_open_timeout;
		s_r.phase == cfm_pkg::ST_WAIT_OPEN && en && fb && s_r.cnt == FB_WINDOW - 32'h1;
	endsequence

	sequence s_close_timeout;
		s_r.phase == cfm_pkg::ST_WAIT_CLOSE && en && !fb && s_r.cnt == FB_WINDOW - 32'h1;
	endsequence

	sequence s_locked_off;
		s_r.locked && !s_r.safety_switch_output;
	endsequence

	property p_enable_gates;
		s_r.phase == cfm_pkg::ST_WAIT_OPEN && !en && RELEASE_REQ && !NONLOCK_FAULT
			|=> s_r.phase == cfm_pkg::ST_ON;
	endproperty
	a_enable_gates: assert property (p_enable_gates) else $error("disabled check still waited");

	property p_closed_before_on;
		$rose(s_r.safety_switch_output) && $past(en) |-> $past(fb);
	endproperty
	a_closed_before_on: assert property (p_closed_before_on) else $error("switched on with open feedback");

	property p_open_fault;
		s_open_timeout |=> s_locked_off ##0 s_r.disp == cfm_pkg::DISP_FB_OPEN_ERR;
	endproperty
	a_open_fault: assert property (p_open_fault) else $error("open timeout not handled");

	property p_close_fault;
		s_close_timeout |=> s_locked_off ##0 s_r.feedback_close_error;
	endproperty
	a_close_fault: assert property (p_close_fault) else $error("close timeout not handled");

	property p_window_bound;
		s_r.phase == cfm_pkg::ST_WAIT_OPEN || s_r.phase == cfm_pkg::ST_WAIT_CLOSE |-> s_r.cnt < FB_WINDOW;
	endproperty
	a_window_bound: assert property (p_window_bound) else $error("window counter overran");

	property p_error_code;
		s_r.feedback_open_error || s_r.feedback_close_error
			|-> s_r.disp == (s_r.feedback_open_error ? cfm_pkg::DISP_FB_OPEN_ERR : cfm_pkg::DISP_FB_CLOSE_ERR);
	endproperty
	a_error_code: assert property (p_error_code) else $error("wrong error code shown");

	property p_lock_holds;
		s_r.locked |=> s_locked_off [*4];
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("interlock released or output on");

	property p_no_unauth_restart;
		s_r.block_restart || s_r.phase == cfm_pkg::ST_AUTO_HOLD |=> !$rose(s_r.safety_switch_output);
	endproperty
	a_no_unauth_restart: assert property (p_no_unauth_restart) else $error("restart after auto reset");

	property p_channel_fixed;
		s_r.chan_cap |=> $stable(s_r.alternate_light_channel);
	endproperty
	a_channel_fixed: assert property (p_channel_fixed) else $error("light channel changed");

	property p_range_follows;
		s_r.rng_s[1] |=> s_r.reduce;
	endproperty
	a_range_follows: assert property (p_range_follows) else $error("range pin not followed");

	property p_interlock_sticky;
		s_r.locked |=> s_r.locked && !s_r.safety_switch_output;
	endproperty
	a_interlock_sticky: assert property (p_interlock_sticky) else $error("interlock left without reset");

	property p_on_only_from_off;
		$rose(s_r.safety_switch_output) |-> $past(s_r.phase) == cfm_pkg::ST_OFF && $past(s_r.chan_cap);
	endproperty
	a_on_only_from_off: assert property (p_on_only_from_off) else $error("switch-on outside idle phase");

	property p_hold_keeps_off;
		s_r.phase == cfm_pkg::ST_AUTO_HOLD |-> !s_r.safety_switch_output;
	endproperty
	a_hold_keeps_off: assert property (p_hold_keeps_off) else $error("output on during auto reset wait");

	property p_open_code_kept;
		s_r.feedback_open_error |=> s_r.feedback_open_error && s_r.disp == cfm_pkg::DISP_FB_OPEN_ERR;
	endproperty
	a_open_code_kept: assert property (p_open_code_kept) else $error("open error code lost");

endmodule : cfm_monitor

//--- pkg/cfm_pkg.sv
// constants, state type and reset image for the contactor feedback monitor
// assumes a single 50 MHz system clock and power-on reset only
package cfm_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned FB_WINDOW_MS = 500;
	localparam logic [31:0] FB_WINDOW_CYC = 32'(FB_WINDOW_MS * (CLK_HZ / 1000));
	localparam int unsigned AUTORESET_S = 10;
	localparam logic [31:0] AUTORESET_CYC = 32'(AUTORESET_S * CLK_HZ);
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ----------------------------------------
	// display codes
	// ----------------------------------------
	localparam logic [7:0] DISP_DEFAULT_CH = 8'hc1;
	localparam logic [7:0] DISP_ALT_CH = 8'hc2;
	localparam logic [7:0] DISP_FB_OPEN_ERR = 8'h30;
	localparam logic [7:0] DISP_FB_CLOSE_ERR = 8'h31;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_OFF,
		ST_WAIT_OPEN,
		ST_ON,
		ST_WAIT_CLOSE,
		ST_AUTO_HOLD,
		ST_LOCKED
	} cfm_phase_t;

	typedef struct packed {
		cfm_phase_t phase;
		logic [31:0] cnt;
		logic [1:0] fb_s;
		logic [1:0] en_s;
		logic [1:0] pol_s;
		logic [1:0] rng_s;
		logic [1:0] strap_cnt;
		logic chan_cap;
		logic alternate_light_channel;
		logic reduce;
		logic safety_switch_output;
		logic feedback_open_error;
		logic feedback_close_error;
		logic locked;
		logic block_restart;
		logic [7:0] disp;
	} cfm_state_t;

	localparam cfm_state_t CFM_RESET = '{
		phase: ST_OFF,
		cnt: 32'h0,
		fb_s: 2'h0,
		en_s: 2'h0,
		pol_s: 2'h0,
		rng_s: 2'h0,
		strap_cnt: 2'h0,
		chan_cap: 1'b0,
		alternate_light_channel: 1'b0,
		reduce: 1'b0,
		safety_switch_output: 1'b0,
		feedback_open_error: 1'b0,
		feedback_close_error: 1'b0,
		locked: 1'b0,
		block_restart: 1'b0,
		disp: DISP_DEFAULT_CH
	};

endpackage : cfm_pkg

//--- verification/cfm_contactor_model.sv
// behavioural model of a contactor with positively guided feedback contact
// assumes coil follows the safety switching output, sampled on the system clock
module cfm_contactor_model #(
	parameter int DELAY = 3
) (
	input wire logic clk,
	input wire logic coil,
	input wire logic [1:0] fault_mode,
	output logic fb_closed
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// contact follows coil after a delay
	// ----------------------------------------
	logic [3:0] cnt_r = 4'h0;
	logic closed_r = 1'b1;
	// contact opens when energised, closes when released
	always_ff @(posedge clk)
	begin
		if (coil == closed_r)
		begin
			if (cnt_r == 4'(DELAY))
			begin
				closed_r <= !coil;
				cnt_r <= 4'h0;
			end
			else
				cnt_r <= cnt_r + 4'h1;
		end
		else
			cnt_r <= 4'h0;
	end
	// mode 1 welded shut, mode 2 never recloses; only scenarios set these
	assign fb_closed = (fault_mode == 2'h1) ? 1'b1 : (fault_mode == 2'h2) ? 1'b0 : closed_r;
endmodule : cfm_contactor_model

//--- verification/contactor_feedback_monitor_test.sv
// self-checking bench for the contactor feedback monitor
// assumes windows shortened to 20 and 50 cycles through parameters
module contactor_feedback_monitor_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FBW = 20;
	localparam int ARC = 50;
	logic clock = 1'b0, resetn = 1'b0, en = 1'b1, pol = 1'b0, rng = 1'b0, req = 1'b0, nlf = 1'b0;
	logic [7:0] nlc = 8'h00;
	logic [1:0] mode = 2'h0;
	logic fb, sso, oerr, cerr, lock, alt, red;
	logic [7:0] disp;
	int n_fail = 0, checks_done = 0, cyc = 0, k;
	always #10 clock = ~clock;
	cfm_contactor_model #(.DELAY(3)) far (.clk(clock), .coil(sso), .fault_mode(mode), .fb_closed(fb));
	cfm_monitor #(.FB_WINDOW(32'h14), .AUTORESET(32'h32)) uut (.CLOCK(clock), .RESETN(resetn),
		.FEEDBACK_CLOSED(fb), .FEEDBACK_CHECK_EN(en), .SUPPLY_POLARITY_REV(pol), .RANGE_SELECT_PIN(rng),
		.RELEASE_REQ(req), .NONLOCK_FAULT(nlf), .NONLOCK_CODE(nlc), .SAFETY_SWITCH_OUTPUT(sso),
		.FEEDBACK_OPEN_ERROR(oerr), .FEEDBACK_CLOSE_ERROR(cerr), .FAULT_INTERLOCK(lock),
		.ALTERNATE_LIGHT_CHANNEL(alt), .REDUCED_LIGHT_POWER(red), .DISPLAY_CODE(disp));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// inputs move 1 ns after the edge so no race with the design
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task automatic wait_sso(input logic v);
		k = 0;
		while (sso !== v && k < 40)
		begin
			step(1);
			k++;
		end
	endtask : wait_sso
	task automatic do_reset(input logic p, input logic r);
		resetn = 1'b0;
		pol = p;
		rng = r;
		req = 1'b0;
		mode = 2'h0;
		step(20);
		resetn = 1'b1;
		step(6);
	endtask : do_reset
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_straps();
		do_reset(1'b0, 1'b0);
		chk("alt", 8'h00, 8'(alt));
		chk("disp", cfm_pkg::DISP_DEFAULT_CH, disp);
		chk("red", 8'h00, 8'(red));
		do_reset(1'b1, 1'b1);
		chk("alt", 8'h01, 8'(alt));
		chk("disp", cfm_pkg::DISP_ALT_CH, disp);
		chk("red", 8'h01, 8'(red));
		rng = 1'b0;
		step(4);
		chk("red", 8'h00, 8'(red));
	endtask : t_straps
	task automatic t_normal();
		do_reset(1'b0, 1'b0);
		req = 1'b1;
		wait_sso(1'b1);
		chk("sso", 8'h01, 8'(sso));
		step(FBW + 5);
		chk("sso", 8'h01, 8'(sso));
		chk("oerr", 8'h00, 8'(oerr));
		req = 1'b0;
		step(2);
		chk("sso", 8'h00, 8'(sso));
		step(FBW + 5);
		chk("cerr", 8'h00, 8'(cerr));
		req = 1'b1;
		wait_sso(1'b1);
		chk("sso", 8'h01, 8'(sso));
		req = 1'b0;
		step(FBW + 5);
		chk("lock", 8'h00, 8'(lock));
	endtask : t_normal
	task automatic t_refuse();
		do_reset(1'b0, 1'b0);
		mode = 2'h2;
		// let the open contact pass the synchroniser before asking
		step(3);
		req = 1'b1;
		step(30);
		chk("sso", 8'h00, 8'(sso));
		mode = 2'h0;
		wait_sso(1'b1);
		chk("sso", 8'h01, 8'(sso));
		req = 1'b0;
		step(FBW + 5);
	endtask : t_refuse
	task automatic t_open_fail();
		do_reset(1'b0, 1'b0);
		mode = 2'h1;
		req = 1'b1;
		wait_sso(1'b1);
		k = 0;
		while (sso === 1'b1 && k < 100)
		begin
			step(1);
			k++;
		end
		chk("on_cycles", 8'(FBW), 8'(k));
		chk("sso", 8'h00, 8'(sso));
		chk("oerr", 8'h01, 8'(oerr));
		chk("disp", cfm_pkg::DISP_FB_OPEN_ERR, disp);
		mode = 2'h0;
		req = 1'b0;
		step(3);
		req = 1'b1;
		step(FBW + 5);
		chk("sso", 8'h00, 8'(sso));
		chk("lock", 8'h01, 8'(lock));
	endtask : t_open_fail
	task automatic t_close_fail();
		do_reset(1'b0, 1'b0);
		chk("lock", 8'h00, 8'(lock));
		req = 1'b1;
		wait_sso(1'b1);
		step(10);
		mode = 2'h2;
		req = 1'b0;
		wait_sso(1'b0);
		step(FBW - 1);
		chk("cerr", 8'h00, 8'(cerr));
		step(1);
		chk("cerr", 8'h01, 8'(cerr));
		chk("disp", cfm_pkg::DISP_FB_CLOSE_ERR, disp);
		chk("lock", 8'h01, 8'(lock));
	endtask : t_close_fail
	task automatic t_disabled();
		en = 1'b0;
		do_reset(1'b0, 1'b0);
		mode = 2'h1;
		req = 1'b1;
		wait_sso(1'b1);
		step(FBW + 10);
		chk("sso", 8'h01, 8'(sso));
		req = 1'b0;
		step(FBW + 5);
		chk("lock", 8'h00, 8'(lock));
		en = 1'b1;
	endtask : t_disabled
	task automatic t_nonlock();
		do_reset(1'b0, 1'b0);
		req = 1'b1;
		wait_sso(1'b1);
		step(10);
		nlf = 1'b1;
		nlc = 8'h5a;
		step(1);
		nlf = 1'b0;
		step(1);
		chk("sso", 8'h00, 8'(sso));
		chk("disp", 8'h5a, disp);
		step(ARC + 5);
		chk("disp", cfm_pkg::DISP_DEFAULT_CH, disp);
		chk("sso", 8'h00, 8'(sso));
		chk("lock", 8'h00, 8'(lock));
		req = 1'b0;
		step(10);
		req = 1'b1;
		wait_sso(1'b1);
		chk("sso", 8'h01, 8'(sso));
		req = 1'b0;
		step(FBW + 5);
	endtask : t_nonlock
	// ----------------------------------------
	// sequence and hang guard
	// ----------------------------------------
	// ceiling well above the roughly 600 cycles the scenarios need
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			wrap_up();
		end
	end
	initial
	begin
		t_straps();
		t_normal();
		t_refuse();
		t_open_fail();
		t_close_fail();
		t_disabled();
		t_nonlock();
		wrap_up();
	end
endmodule : contactor_feedback_monitor_test
